// *** rtl/rcs_top.v ***
`include "rcs_defines.vh"

module rcs_top #(
	parameter FW = 16
) (
	input wire clk_i,
	input wire sys_rst_i,
	input wire input_terminal_1_i,
	input wire input_terminal_2_i,
	input wire step_select_bit0_i,
	input wire step_select_bit1_i,
	input wire step_select_bit2_i,
	input wire [4:0] terminal1_function_i,
	input wire [4:0] terminal2_function_i,
	input wire [4:0] terminal6_function_i,
	input wire [4:0] terminal7_function_i,
	input wire [4:0] terminal8_function_i,
	input wire [2:0] run_source_i,
	input wire [3:0] freq_mode_i,
	input wire [FW-1:0] base_freq_cmd_i,
	input wire [FW-1:0] analog_freq_ref_i,
	input wire bipolar_analog_input_neg_i,
	input wire keypad_direction_sel_i,
	input wire builtin_run_key_i,
	input wire builtin_stop_key_i,
	input wire remote_keypad_present_i,
	input wire remote_run_key_i,
	input wire remote_stop_key_i,
	input wire serial_run_cmd_i,
	input wire serial_reverse_i,
	input wire [1:0] direction_inhibit_i,
	input wire power_on_start_en_i,
	input wire fault_reset_restart_en_i,
	input wire fault_active_i,
	input wire motor_stopped_i,
	input wire step_wr_i,
	input wire [2:0] step_wr_index_i,
	input wire [FW-1:0] step_wr_data_i,
	output wire run_o,
	output wire reverse_o,
	output wire reversing_o,
	output reg [FW-1:0] freq_ref_o,
	output reg [2:0] step_index_o,
	output reg run_refused_o
);
	// One-hot run states
	localparam [2:0] ST_STOP = 3'h1;
	localparam [2:0] ST_RUN = 3'h2;
	localparam [2:0] ST_REVERSING = 3'h4;

	// True when any terminal assigned the given function is active
	function term_hit;
		input [5*`RCS_FN_W-1:0] fn;
		input [4:0] lv;
		input [`RCS_FN_W-1:0] code;
		integer k;
		begin
			term_hit = 1'b0;
			for (k = 0; k < 5; k = k + 1) begin
				if (lv[k] && fn[k*`RCS_FN_W +: `RCS_FN_W] == code) begin
					term_hit = 1'b1;
				end
			end
		end
	endfunction

	// Power-up contents of the step table
	function [FW-1:0] step_default;
		input [2:0] idx;
		begin
			case (idx)
				3'h1: step_default = `RCS_STEP1_RST;
				3'h2: step_default = `RCS_STEP2_RST;
				3'h3: step_default = `RCS_STEP3_RST;
				3'h4: step_default = `RCS_STEP4_RST;
				3'h5: step_default = `RCS_STEP5_RST;
				3'h6: step_default = `RCS_STEP6_RST;
				3'h7: step_default = `RCS_STEP7_RST;
				default: step_default = {FW{1'b0}};
			endcase
		end
	endfunction

	wire [`RCS_PIN_W-1:0] pin_raw;
	wire [`RCS_PIN_W-1:0] pin_s;
	// Pin levels one edge older than pin_s
	reg [`RCS_PIN_W-1:0] pin_q;
	reg [FW-1:0] step_tab [1:7];
	reg [2:0] state;
	reg [2:0] next_state;
	reg motor_rev;
	reg next_motor_rev;
	reg kp_run;
	reg kp_rev;
	reg term_ok;
	reg [2:0] boot;
	reg [4:0] lv;
	reg [5*`RCS_FN_W-1:0] fn;
	reg fwd_in;
	reg rev_in;
	reg [2:0] step_idx;
	reg term_src;
	reg term_run_raw;
	reg req_run;
	reg req_rev;
	reg blocked;
	reg eff_run;
	reg [FW-1:0] sel_freq;
	reg kp_run_press;
	reg kp_stop_press;
	integer i;

	assign pin_raw = {remote_stop_key_i, remote_run_key_i, remote_keypad_present_i,
		builtin_stop_key_i, builtin_run_key_i, bipolar_analog_input_neg_i,
		step_select_bit2_i, step_select_bit1_i, step_select_bit0_i,
		input_terminal_2_i, input_terminal_1_i};

	// Every pin crosses two flops first
	rcs_sync #(
		.W(`RCS_PIN_W)
	) u_sync (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.d_i(pin_raw),
		.q_o(pin_s)
	);

	// One more stage gives the previous value for key edges
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			pin_q <= {`RCS_PIN_W{1'b0}};
		end else begin
			pin_q <= pin_s;
		end
	end

	// Built-in keys are ignored while a remote keypad is attached
	always @* begin
		if (pin_s[`RCS_PIN_RPRES]) begin
			kp_run_press = pin_s[`RCS_PIN_RRUN] & ~pin_q[`RCS_PIN_RRUN];
			kp_stop_press = pin_s[`RCS_PIN_RSTOP] & ~pin_q[`RCS_PIN_RSTOP];
		end else begin
			kp_run_press = pin_s[`RCS_PIN_BRUN] & ~pin_q[`RCS_PIN_BRUN];
			kp_stop_press = pin_s[`RCS_PIN_BSTOP] & ~pin_q[`RCS_PIN_BSTOP];
		end
	end

	// Terminal functions and step index, all from registered levels
	always @* begin
		lv = {pin_s[`RCS_PIN_T8], pin_s[`RCS_PIN_T7], pin_s[`RCS_PIN_T6],
			pin_s[`RCS_PIN_T2], pin_s[`RCS_PIN_T1]};
		fn = {terminal8_function_i, terminal7_function_i, terminal6_function_i,
			terminal2_function_i, terminal1_function_i};
		fwd_in = term_hit(fn, lv, `RCS_FN_FWD_RUN);
		rev_in = term_hit(fn, lv, `RCS_FN_REV_RUN);
		step_idx[0] = term_hit(fn, lv, `RCS_FN_STEP_B0);
		step_idx[1] = term_hit(fn, lv, `RCS_FN_STEP_B1);
		step_idx[2] = term_hit(fn, lv, `RCS_FN_STEP_B2);
	end

	// Run request from the selected source
	always @* begin
		term_src = 1'b0;
		term_run_raw = 1'b0;
		req_run = 1'b0;
		req_rev = `RCS_DIR_FWD;
		case (run_source_i)
			`RCS_SRC_KEYPAD: begin
				req_run = kp_run;
				req_rev = kp_rev;
			end
			`RCS_SRC_TERM_FR: begin
				term_src = 1'b1;
				term_run_raw = fwd_in ^ rev_in;
				req_run = term_run_raw & term_ok;
				req_rev = rev_in;
			end
			`RCS_SRC_TERM_RD: begin
				term_src = 1'b1;
				term_run_raw = fwd_in;
				req_run = term_run_raw & term_ok;
				req_rev = rev_in;
			end
			`RCS_SRC_SERIAL: begin
				req_run = serial_run_cmd_i;
				req_rev = serial_reverse_i;
			end
			default: begin
				req_run = 1'b0;
				req_rev = `RCS_DIR_FWD;
			end
		endcase
		if (freq_mode_i == `RCS_FRQ_BIPOLAR && pin_s[`RCS_PIN_BNEG]) begin
			req_rev = ~req_rev;
		end
		blocked = (direction_inhibit_i == `RCS_INH_FWD && !req_rev) ||
			(direction_inhibit_i == `RCS_INH_REV && req_rev);
		eff_run = req_run & ~blocked & ~fault_active_i;
	end

	// Keypad run latch; stop has priority over a run press in the same cycle
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			kp_run <= 1'b0;
			kp_rev <= `RCS_DIR_FWD;
		end else begin
			kp_rev <= keypad_direction_sel_i;
			if (run_source_i != `RCS_SRC_KEYPAD || fault_active_i || kp_stop_press) begin
				kp_run <= 1'b0;
			end else if (kp_run_press) begin
				kp_run <= 1'b1;
			end
		end
	end

	// A terminal run level held through power-up or a fault needs permission;
	// otherwise it must first drop before it can start the motor.
	// Sync flops are cleared by reset, so the true pin level is first seen on
	// the third edge after release; no terminal start is allowed before that.
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			boot <= 3'h7;
			term_ok <= 1'b0;
		end else begin
			boot <= {1'b0, boot[2:1]};
			if (boot == 3'h1) begin
				term_ok <= power_on_start_en_i | ~term_run_raw;
			end else if (boot != 3'h0) begin
				term_ok <= 1'b0;
			end else if (fault_active_i) begin
				term_ok <= fault_reset_restart_en_i | ~term_run_raw;
			end else if (!term_run_raw) begin
				term_ok <= 1'b1;
			end
		end
	end

	// Step frequency table; index 0 is never written, step 0 follows the mode
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			for (i = 1; i < 8; i = i + 1) begin
				step_tab[i] <= step_default(i[2:0]);
			end
		end else if (step_wr_i && step_wr_index_i != 3'h0) begin
			step_tab[step_wr_index_i] <= step_wr_data_i;
		end
	end

	// Step 0 follows the frequency mode; other steps read the table
	always @* begin
		if (step_idx == 3'h0) begin
			if (freq_mode_i == `RCS_FRQ_KEYPAD) begin
				sel_freq = base_freq_cmd_i;
			end else begin
				sel_freq = analog_freq_ref_i;
			end
		end else begin
			sel_freq = step_tab[step_idx];
		end
	end

	// Direction changes while running go through zero speed
	always @* begin
		next_state = state;
		next_motor_rev = motor_rev;
		case (state)
			ST_STOP: begin
				if (eff_run) begin
					next_state = ST_RUN;
					next_motor_rev = req_rev;
				end
			end
			ST_RUN: begin
				if (!eff_run) begin
					next_state = ST_STOP;
				end else if (req_rev != motor_rev) begin
					next_state = ST_REVERSING;
				end
			end
			ST_REVERSING: begin
				if (!eff_run) begin
					next_state = ST_STOP;
				end else if (motor_stopped_i) begin
					next_state = ST_RUN;
					next_motor_rev = req_rev;
				end
			end
			default: begin
				next_state = ST_STOP;
			end
		endcase
	end

	// Frequency is given only while running in a settled direction
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			state <= ST_STOP;
			motor_rev <= `RCS_DIR_FWD;
			freq_ref_o <= {FW{1'b0}};
			step_index_o <= 3'h0;
			run_refused_o <= 1'b0;
		end else begin
			state <= next_state;
			motor_rev <= next_motor_rev;
			run_refused_o <= req_run & blocked;
			step_index_o <= step_idx;
			if (next_state == ST_RUN) begin
				freq_ref_o <= sel_freq;
			end else begin
				freq_ref_o <= {FW{1'b0}};
			end
		end
	end

	// Run and direction outputs come straight from state flops
	assign run_o = (state != ST_STOP);
	assign reverse_o = motor_rev;
	assign reversing_o = (state == ST_REVERSING);
endmodule // rcs_top

// *** rtl/rcs_defines.vh ***
`ifndef RCS_DEFINES_VH
`define RCS_DEFINES_VH

// Terminal function codes
`define RCS_FN_FWD_RUN 5'h00
`define RCS_FN_REV_RUN 5'h01
`define RCS_FN_STEP_B0 5'h05
`define RCS_FN_STEP_B1 5'h06
`define RCS_FN_STEP_B2 5'h07
`define RCS_FN_W 5

// Run source settings
`define RCS_SRC_KEYPAD 3'h0
`define RCS_SRC_TERM_FR 3'h1
`define RCS_SRC_TERM_RD 3'h2
`define RCS_SRC_SERIAL 3'h3

// Frequency source settings
`define RCS_FRQ_KEYPAD 4'h0
`define RCS_FRQ_BIPOLAR 4'h2

// Direction codes (keypad direction F / r)
`define RCS_DIR_FWD 1'b0
`define RCS_DIR_REV 1'b1

// Direction inhibit settings
`define RCS_INH_NONE 2'h0
`define RCS_INH_FWD 2'h1
`define RCS_INH_REV 2'h2

// Step frequency reset values, 0.01 Hz units
`define RCS_STEP1_RST 16'h03E8
`define RCS_STEP2_RST 16'h07D0
`define RCS_STEP3_RST 16'h0BB8
`define RCS_STEP4_RST 16'h0BB8
`define RCS_STEP5_RST 16'h09C4
`define RCS_STEP6_RST 16'h07D0
`define RCS_STEP7_RST 16'h05DC

// Synchronised pin vector bit positions
`define RCS_PIN_T1 0
`define RCS_PIN_T2 1
`define RCS_PIN_T6 2
`define RCS_PIN_T7 3
`define RCS_PIN_T8 4
`define RCS_PIN_BNEG 5
`define RCS_PIN_BRUN 6
`define RCS_PIN_BSTOP 7
`define RCS_PIN_RPRES 8
`define RCS_PIN_RRUN 9
`define RCS_PIN_RSTOP 10
`define RCS_PIN_W 11

`endif

// *** rtl/rcs_sync.v ***
module rcs_sync #(
	parameter W = 1
) (
	input wire clk_i,
	input wire sys_rst_i,
	input wire [W-1:0] d_i,
	output reg [W-1:0] q_o
);
	reg [W-1:0] meta;

	// First stage feeds only the second stage
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			meta <= {W{1'b0}};
			q_o <= {W{1'b0}};
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule // rcs_sync

// *** bench/rcs_top_monitor.sv ***
module rcs_mon #(
	parameter FW = 16
) (
	input logic clk_i,
	input logic sys_rst_i,
	input logic step_select_bit0_i,
	input logic step_select_bit1_i,
	input logic step_select_bit2_i,
	input logic input_terminal_1_i,
	input logic input_terminal_2_i,
	input logic [2:0] run_source_i,
	input logic [1:0] direction_inhibit_i,
	input logic serial_run_cmd_i,
	input logic fault_active_i,
	input logic motor_stopped_i,
	input logic run_o,
	input logic reverse_o,
	input logic reversing_o,
	input logic [FW-1:0] freq_ref_o,
	input logic [2:0] step_index_o,
	input logic run_refused_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pins reach the outputs three edges later, so pin history needs three edges
	logic [1:0] up;
	always @(posedge clk_i) begin
		up <= sys_rst_i ? 2'h0 : (up == 2'h3 ? up : up + 2'h1);
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_turn;
		reversing_o && motor_stopped_i;
	endsequence
	sequence s_new_dir;
		run_o && !reversing_o && reverse_o != $past(reverse_o);
	endsequence
	AST_IDLE: assert property (!run_o |-> freq_ref_o == 0)
		else $error("freq while stopped");
	AST_REFUSE: assert property (run_refused_o |-> !run_o && freq_ref_o == 0)
		else $error("refused run not held");
	AST_STEP: assert property (up == 2'h3 |-> step_index_o == {$past(step_select_bit2_i, 3),
		$past(step_select_bit1_i, 3), $past(step_select_bit0_i, 3)}) else $error("step index");
	AST_BOTH: assert property (up == 2'h3 && $past(run_source_i) == 3'h1 &&
		$past(input_terminal_1_i, 3) == $past(input_terminal_2_i, 3) |-> !run_o)
		else $error("run with both or neither");
	AST_SER: assert property ($past(run_source_i) == 3'h3 && !$past(serial_run_cmd_i) |-> !run_o)
		else $error("serial stop ignored");
	AST_FLT: assert property ($past(fault_active_i) |-> !run_o)
		else $error("run during fault");
	AST_INH: assert property (run_o && !reversing_o |->
		$past(direction_inhibit_i) != (reverse_o ? 2'h2 : 2'h1)) else $error("inhibited dir");
	AST_TURN: assert property (s_turn |=> s_new_dir)
		else $error("no reverse after stop");
endmodule // rcs_mon

bind rcs_top rcs_mon #(.FW(FW)) mon (.clk_i, .sys_rst_i, .step_select_bit0_i,
	.step_select_bit1_i, .step_select_bit2_i, .input_terminal_1_i, .input_terminal_2_i,
	.run_source_i, .direction_inhibit_i, .serial_run_cmd_i, .fault_active_i,
	.motor_stopped_i, .run_o, .reverse_o, .reversing_o, .freq_ref_o, .step_index_o,
	.run_refused_o);

// *** bench/rcs_panel.sv ***
module rcs_panel #(
	parameter int SLOW = 5
) (
	input logic clk_i,
	input logic [8:0] want_i,
	input logic reversing_i,
	output logic [8:0] pin_o,
	output logic stopped_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt = 4'h0;
	initial pin_o = 9'h000;
	initial stopped_o = 1'b0;
	// Contacts move only just after an edge; the load needs SLOW+1 cycles to coast down
	always @(posedge clk_i) begin
		pin_o <= want_i;
		cnt <= reversing_i ? cnt + 4'h1 : 4'h0;
		stopped_o <= reversing_i && cnt == SLOW[3:0];
	end
endmodule // rcs_panel

// *** bench/tb_rcs_top.sv ***
module tb_rcs_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [8:0] want = 9'h000;
	logic [8:0] pins;
	logic [24:0] fns = {5'h07, 5'h06, 5'h05, 5'h01, 5'h00};
	logic [2:0] src = 3'h1;
	logic [3:0] fmode = 4'h0;
	logic [1:0] inh = 2'h0;
	logic [15:0] base = 16'h1234;
	logic neg = 1'b0, kdir = 1'b0, scmd = 1'b0, pon = 1'b0, ren = 1'b0, flt = 1'b0, stp;
	logic run_o, reverse_o, reversing_o, run_refused_o;
	logic [15:0] freq_ref_o;
	logic [2:0] step_index_o;
	logic [15:0] steps [8] = '{16'h1234, 16'h03E8, 16'h07D0, 16'h0BB8, 16'h0BB8, 16'h09C4,
		16'h07D0, 16'h05DC};
	int mismatches = 0;
	int samples_checked = 0;
	always #10 clk_i = ~clk_i;
	rcs_top dut (.clk_i, .sys_rst_i, .input_terminal_1_i(pins[0]), .input_terminal_2_i(pins[1]),
		.step_select_bit0_i(pins[2]), .step_select_bit1_i(pins[3]), .step_select_bit2_i(pins[4]),
		.terminal1_function_i(fns[4:0]), .terminal2_function_i(fns[9:5]),
		.terminal6_function_i(fns[14:10]), .terminal7_function_i(fns[19:15]),
		.terminal8_function_i(fns[24:20]), .run_source_i(src), .freq_mode_i(fmode),
		.base_freq_cmd_i(base), .analog_freq_ref_i(16'h0ABC), .bipolar_analog_input_neg_i(neg),
		.keypad_direction_sel_i(kdir), .builtin_run_key_i(pins[5]), .builtin_stop_key_i(pins[6]),
		.remote_keypad_present_i(pins[8]), .remote_run_key_i(pins[7]), .remote_stop_key_i(1'b0),
		.serial_run_cmd_i(scmd), .serial_reverse_i(kdir), .direction_inhibit_i(inh),
		.power_on_start_en_i(pon), .fault_reset_restart_en_i(ren), .fault_active_i(flt),
		.motor_stopped_i(stp), .step_wr_i(1'b0), .step_wr_index_i(3'h0),
		.step_wr_data_i(16'h0000), .run_o, .reverse_o, .reversing_o, .freq_ref_o,
		.step_index_o, .run_refused_o);
	rcs_panel panel (.clk_i, .want_i(want), .reversing_i(reversing_o), .pin_o(pins),
		.stopped_o(stp));
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Panel adds one edge to the pin path and key edge detection one more;
	// outputs are read one edge after they settle, never at their launch edge
	task automatic go(logic [8:0] w);
		want <= w;
		repeat (6) @(posedge clk_i);
	endtask
	task automatic until_dir(logic v);
		for (int n = 0; reverse_o !== v; n++) begin
			if (n > 30) begin
				mismatches++;
				close_out();
			end
			@(posedge clk_i);
		end
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			go({4'h0, i[2:0], 2'b01});
			chk("freq", freq_ref_o, steps[i]);
			chk("step", {13'h0, step_index_o}, {13'h0, i[2:0]});
		end
		go(9'h003);
		chk("both", {15'h0, run_o}, 16'h0000);
		inh <= 2'h1;
		go(9'h001);
		chk("fwd block", {15'h0, run_refused_o}, 16'h0001);
		go(9'h002);
		chk("rev", {14'h0, run_o, reverse_o}, 16'h0003);
		inh <= 2'h2;
		go(9'h002);
		chk("held", freq_ref_o, 16'h0000);
		inh <= 2'h0;
		src <= 3'h2;
		go(9'h000);
		go(9'h001);
		chk("dir2", {14'h0, run_o, reverse_o}, 16'h0002);
		want <= 9'h003;
		until_dir(1'b1);
		src <= 3'h1;
		fmode <= 4'h2;
		go(9'h000);
		go(9'h001);
		chk("analog", freq_ref_o, 16'h0ABC);
		neg <= 1'b1;
		until_dir(1'b1);
		src <= 3'h0;
		fmode <= 4'h0;
		kdir <= 1'b1;
		go(9'h000);
		go(9'h020);
		chk("key", {14'h0, run_o, reverse_o}, 16'h0003);
		go(9'h040);
		chk("key stop", {15'h0, run_o}, 16'h0000);
		go(9'h100);
		go(9'h120);
		chk("builtin", {15'h0, run_o}, 16'h0000);
		go(9'h180);
		chk("remote", {15'h0, run_o}, 16'h0001);
		src <= 3'h3;
		scmd <= 1'b1;
		go(9'h001);
		chk("serial", {15'h0, run_o}, 16'h0001);
		src <= 3'h1;
		ren <= 1'b1;
		flt <= 1'b1;
		go(9'h001);
		flt <= 1'b0;
		go(9'h001);
		chk("restart", {15'h0, run_o}, 16'h0001);
		sys_rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk("no pon", {15'h0, run_o}, 16'h0000);
		pon <= 1'b1;
		sys_rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk("pon", {15'h0, run_o}, 16'h0001);
		close_out();
	end
endmodule // tb_rcs_top
